//--- async_timer.sv
// asynchronous 8-bit timer with shadowed register updates behind apb
`timescale 1ns/1ps
module async_timer
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // apb slave
    input async_timer_pkg::apb_req_t apb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // oscillator pin and sleep state
    input wire logic timer_osc_input,
    input wire logic sleep_save,
    input wire logic sleep_down,
    // timer outputs
    output logic compare_pin,
    output logic compare_flag,
    output logic overflow_flag,
    output logic wake_request
);
    import async_timer_pkg::*;
    `include "async_timer_defs.svh"

    logic osc_meta, osc_sync, osc_last;
    logic async_clock_select, next_async_clock_select;
    logic osc_tick, count_en, setup, access, wr_en;
    logic [7:0] async_counter_value, next_counter;
    logic [7:0] async_compare_value, next_compare;
    timer_ctrl_t async_timer_control, next_control;
    logic [2:0] slot_write, slot_load, slot_busy;
    logic [7:0] slot_hold [3];
    logic match_evt, ovf_evt, next_match_evt, next_ovf_evt;
    logic next_compare_pin;
    logic [`FLAG_SYNC_STAGES-1:0] match_pipe, ovf_pipe;
    logic next_compare_flag, next_overflow_flag;
    logic compare_irq_enable, overflow_irq_enable, next_cie, next_oie;
    logic [7:0] async_timer_status;
    logic [31:0] next_prdata;
    logic next_pslverr, bad_addr;
    wake_state_t wake_state, next_wake_state;
    logic next_wake_request, irq_cond;

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == `OFS_COUNTER) || (a == `OFS_COMPARE) || (a == `OFS_CONTROL)
            || (a == `OFS_STATUS) || (a == `OFS_FLAGS);
    endfunction : addr_known

    // oscillator pin: two stages before anything looks at it
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
            osc_last <= 1'b0;
        end
        else
        begin
            osc_meta <= timer_osc_input;
            osc_sync <= osc_meta;
            osc_last <= osc_sync;
        end
    end

    // power-down stops the oscillator, so no ticks arrive; contents then count as lost
    assign osc_tick = !sleep_down && (async_clock_select ? (osc_sync && !osc_last) : 1'b1);

    // apb decode: setup cycle prepares read data, access completes in one cycle
    assign setup = apb.psel && !apb.penable;
    assign access = apb.psel && apb.penable;
    assign pready = access;
    assign wr_en = access && apb.pwrite && addr_known(apb.paddr);
    assign bad_addr = !addr_known(apb.paddr);

    assign slot_write[0] = wr_en && (apb.paddr == `OFS_COUNTER);
    assign slot_write[1] = wr_en && (apb.paddr == `OFS_COMPARE);
    assign slot_write[2] = wr_en && (apb.paddr == `OFS_CONTROL);

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_slot
            update_slot u_slot
            (
                .clk(clk),
                .nrst(nrst),
                .write(slot_write[gi]),
                .wdata(apb.pwdata[7:0]),
                .async_mode(async_clock_select),
                .osc_tick(osc_tick),
                .hold(slot_hold[gi]),
                .load(slot_load[gi]),
                .busy(slot_busy[gi])
            );
        end
    endgenerate

    assign async_timer_status = {4'h0, async_clock_select, slot_busy[0], slot_busy[1],
        slot_busy[2]};

    always_comb
    begin
        next_prdata = prdata;
        next_pslverr = pslverr;
        if (setup)
        begin
            next_pslverr = bad_addr;
            next_prdata = 32'h0000_0000;
            if (apb.paddr == `OFS_COUNTER)
                next_prdata[7:0] = async_counter_value;
            else if (apb.paddr == `OFS_COMPARE)
                next_prdata[7:0] = slot_hold[1];
            else if (apb.paddr == `OFS_CONTROL)
                next_prdata[7:0] = slot_hold[2];
            else if (apb.paddr == `OFS_STATUS)
                next_prdata[7:0] = async_timer_status;
            else if (apb.paddr == `OFS_FLAGS)
            begin
                next_prdata[`BIT_COMPARE_FLAG] = compare_flag;
                next_prdata[`BIT_OVERFLOW_FLAG] = overflow_flag;
                next_prdata[`BIT_COMPARE_IRQ_EN] = compare_irq_enable;
                next_prdata[`BIT_OVERFLOW_IRQ_EN] = overflow_irq_enable;
            end
        end
    end

    tick_prescaler u_prescaler
    (
        .clk(clk),
        .nrst(nrst),
        .tick(osc_tick),
        .clk_sel(async_timer_control.clk_sel),
        .count_en(count_en)
    );

    // timer core: counts on prescaled ticks, destinations load from holding registers
    always_comb
    begin
        next_counter = async_counter_value;
        next_compare = async_compare_value;
        next_control = async_timer_control;
        next_compare_pin = compare_pin;
        next_match_evt = 1'b0;
        next_ovf_evt = 1'b0;
        next_async_clock_select = async_clock_select;
        // only the select bit is writable; busy positions ignore writes
        if (wr_en && apb.paddr == `OFS_STATUS)
            next_async_clock_select = apb.pwdata[`BIT_CLOCK_SELECT];
        if (count_en)
        begin
            next_counter = async_counter_value + 8'h01;
            if (async_counter_value == `COUNT_TOP)
                next_ovf_evt = 1'b1;
            // a pending counter or compare update blocks the match
            if (async_counter_value == async_compare_value && !slot_busy[0] && !slot_busy[1])
            begin
                next_match_evt = 1'b1;
                if (async_timer_control.clear_on_match)
                    next_counter = `RESET_BYTE;
                case (async_timer_control.out_mode)
                    `OUT_TOGGLE: next_compare_pin = !compare_pin;
                    `OUT_CLEAR: next_compare_pin = 1'b0;
                    `OUT_SET: next_compare_pin = 1'b1;
                    default: next_compare_pin = compare_pin;
                endcase
            end
        end
        if (slot_load[0])
            next_counter = slot_hold[0];
        if (slot_load[1])
            next_compare = slot_hold[1];
        if (slot_load[2])
            next_control = timer_ctrl_t'(slot_hold[2]);
    end

    // event flags cross in three cycles; a new event beats a clear in the same cycle
    always_comb
    begin
        next_compare_flag = compare_flag;
        next_overflow_flag = overflow_flag;
        next_cie = compare_irq_enable;
        next_oie = overflow_irq_enable;
        if (wr_en && apb.paddr == `OFS_FLAGS)
        begin
            if (apb.pwdata[`BIT_COMPARE_FLAG])
                next_compare_flag = 1'b0;
            if (apb.pwdata[`BIT_OVERFLOW_FLAG])
                next_overflow_flag = 1'b0;
            next_cie = apb.pwdata[`BIT_COMPARE_IRQ_EN];
            next_oie = apb.pwdata[`BIT_OVERFLOW_IRQ_EN];
        end
        if (match_pipe[`FLAG_SYNC_STAGES-1])
            next_compare_flag = 1'b1;
        if (ovf_pipe[`FLAG_SYNC_STAGES-1])
            next_overflow_flag = 1'b1;
    end

    assign irq_cond = (match_evt && compare_irq_enable) || (ovf_evt && overflow_irq_enable);

    // wake sequencing: start on the next tick, then wait one tick to rearm
    always_comb
    begin
        next_wake_state = wake_state;
        next_wake_request = 1'b0;
        case (wake_state)
            wake_awake:
                if (sleep_save)
                    next_wake_state = wake_sleeping;
            wake_sleeping:
                if (!sleep_save)
                    next_wake_state = wake_awake;
                else if (irq_cond)
                    next_wake_state = wake_pending;
            wake_pending:
                if (osc_tick)
                begin
                    next_wake_request = 1'b1;
                    next_wake_state = wake_rearm;
                end
            wake_rearm:
                if (osc_tick)
                    next_wake_state = wake_awake;
            default:
                next_wake_state = wake_awake;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            async_counter_value <= `RESET_BYTE;
            async_compare_value <= `RESET_BYTE;
            async_timer_control <= timer_ctrl_t'(`RESET_BYTE);
            async_clock_select <= 1'b0;
            compare_pin <= 1'b0;
            match_evt <= 1'b0;
            ovf_evt <= 1'b0;
            match_pipe <= '0;
            ovf_pipe <= '0;
            compare_flag <= 1'b0;
            overflow_flag <= 1'b0;
            compare_irq_enable <= 1'b0;
            overflow_irq_enable <= 1'b0;
            wake_state <= wake_awake;
            wake_request <= 1'b0;
        end
        else
        begin
            prdata <= next_prdata;
            pslverr <= next_pslverr;
            async_counter_value <= next_counter;
            async_compare_value <= next_compare;
            async_timer_control <= next_control;
            async_clock_select <= next_async_clock_select;
            compare_pin <= next_compare_pin;
            match_evt <= next_match_evt;
            ovf_evt <= next_ovf_evt;
            // pipes start on the timer tick itself so flags land three cycles after the event
            match_pipe <= {match_pipe[`FLAG_SYNC_STAGES-2:0], next_match_evt};
            ovf_pipe <= {ovf_pipe[`FLAG_SYNC_STAGES-2:0], next_ovf_evt};
            compare_flag <= next_compare_flag;
            overflow_flag <= next_overflow_flag;
            compare_irq_enable <= next_cie;
            overflow_irq_enable <= next_oie;
            wake_state <= next_wake_state;
            wake_request <= next_wake_request;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_counter_busy_set: assert property (slot_write[0] && async_clock_select |=> slot_busy[0])
        else $error("counter busy not set after async write");
    chk_compare_busy_set: assert property (slot_write[1] && async_clock_select |=> slot_busy[1])
        else $error("compare busy not set after async write");
    chk_control_busy_set: assert property (slot_write[2] && async_clock_select |=> slot_busy[2])
        else $error("control busy not set after async write");
    chk_counter_read_live: assert property (setup && apb.paddr == `OFS_COUNTER
        |=> prdata[7:0] == $past(async_counter_value))
        else $error("counter read not live value");
    chk_compare_read_hold: assert property (setup && apb.paddr == `OFS_COMPARE
        |=> prdata[7:0] == $past(slot_hold[1]))
        else $error("compare read not holding value");
    chk_no_match_pending: assert property (next_match_evt |-> !slot_busy[0] && !slot_busy[1])
        else $error("compare match while update pending");
    chk_flag_three_cycles: assert property (match_evt |-> ##3 compare_flag)
        else $error("compare flag not set three cycles after event");
    chk_status_reserved: assert property (prdata[31:8] == 24'h0 && async_timer_status[7:4] == 4'h0)
        else $error("reserved status bits not zero");
    chk_busy_read_only: assert property (wr_en && apb.paddr == `OFS_STATUS && !slot_load[0]
        && !slot_busy[0] |=> !slot_busy[0])
        else $error("status write changed busy flag");
    chk_wake_on_tick: assert property (wake_state == wake_pending && osc_tick |=> wake_request)
        else $error("wake not started on timer tick");

    cov_async_counter_write: cover property (slot_write[0] && async_clock_select ##[1:200] !slot_busy[0]);
    cov_compare_match: cover property (match_evt && compare_irq_enable);
    cov_wake_cycle: cover property (wake_state == wake_rearm ##[1:200] wake_state == wake_awake);

endmodule : async_timer

//--- async_timer_defs.svh
// constants for the asynchronous timer register update block
`ifndef ASYNC_TIMER_DEFS_SVH
`define ASYNC_TIMER_DEFS_SVH

`define OFS_COUNTER 8'h00
`define OFS_COMPARE 8'h04
`define OFS_CONTROL 8'h08
`define OFS_STATUS 8'h0C
`define OFS_FLAGS 8'h10

`define BIT_CONTROL_BUSY 0
`define BIT_COMPARE_BUSY 1
`define BIT_COUNTER_BUSY 2
`define BIT_CLOCK_SELECT 3
`define BIT_COMPARE_FLAG 0
`define BIT_OVERFLOW_FLAG 1
`define BIT_COMPARE_IRQ_EN 4
`define BIT_OVERFLOW_IRQ_EN 5

`define RESET_BYTE 8'h00
`define COUNT_TOP 8'hFF
`define TRANSFER_EDGES 2'h2
`define DONE_SYNC_STAGES 2
`define FLAG_SYNC_STAGES 3

`define OUT_TOGGLE 2'h1
`define OUT_CLEAR 2'h2
`define OUT_SET 2'h3

`endif

//--- async_timer_pkg.sv
// types shared by the asynchronous timer register update block
package async_timer_pkg;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [1:0] spare;
        logic [1:0] out_mode;
        logic clear_on_match;
        logic [2:0] clk_sel;
    } timer_ctrl_t;

    typedef enum logic [1:0] {
        wake_awake,
        wake_sleeping,
        wake_pending,
        wake_rearm
    } wake_state_t;

endpackage : async_timer_pkg

//--- async_timer_tb.sv
// self-checking bench for the asynchronous timer register update block
`timescale 1ns/1ps
`include "async_timer_defs.svh"
module async_timer_tb;
    import async_timer_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic timer_osc_input = 1'b0;
    logic sleep_save = 1'b0;
    logic sleep_down = 1'b0;
    apb_req_t apb;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    int n_fail = 0;
    int check_count = 0;
    int seed = 40405;
    // model: counter, compare, control holding values and pending transfers
    logic [7:0] hold[3] = '{8'h00, 8'h00, 8'h00};
    logic busy[3] = '{1'b0, 1'b0, 1'b0};
    int ticks[3] = '{0, 0, 0};
    logic [7:0] live = 8'h00;
    logic [7:0] ofs[3] = '{`OFS_COUNTER, `OFS_COMPARE, `OFS_CONTROL};
    logic [31:0] rd;
    logic err;
    int k;
    logic [7:0] v;
    logic compare_pin, compare_flag, overflow_flag, wake_request;
    int n_wake = 0;

    always #4 clk = ~clk;

    always @(posedge clk)
        if (wake_request === 1'b1)
            n_wake++;

    async_timer async_timer_inst (
        .clk(clk), .nrst(nrst), .apb(apb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_osc_input(timer_osc_input), .sleep_save(sleep_save),
        .sleep_down(sleep_down), .compare_pin(compare_pin), .compare_flag(compare_flag),
        .overflow_flag(overflow_flag), .wake_request(wake_request)
    );

    cpu_core_model cpu_core_model_inst (
        .clk(clk), .apb(apb), .prdata(prdata), .pready(pready), .pslverr(pslverr)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: read %h, model %h", $time, got, exp);
        end
    endtask : check

    task automatic check_err(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: slave error %b, model %b", $time, got, exp);
        end
    endtask : check_err

    task automatic check_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: output %b, model %b", $time, got, exp);
        end
    endtask : check_bit

    task automatic rd_reg(input logic [7:0] addr);
        cpu_core_model_inst.xfer(1'b0, addr, 8'h00, rd, err);
    endtask : rd_reg

    task automatic wr_reg(input logic [7:0] addr, input logic [7:0] wd);
        cpu_core_model_inst.xfer(1'b1, addr, wd, rd, err);
    endtask : wr_reg

    // pin period of 12 clocks keeps it well below a quarter of clk
    task automatic osc_pulse();
        repeat (4) @(posedge clk);
        timer_osc_input <= 1'b1;
        repeat (4) @(posedge clk);
        timer_osc_input <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : osc_pulse

    function automatic logic [31:0] status_exp();
        return {28'h0000000, 1'b1, busy[0], busy[1], busy[2]};
    endfunction : status_exp

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        print_verdict();
    end

    initial
    begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd_reg(`OFS_STATUS);
        check(rd, 32'h00000000);
        wr_reg(`OFS_COMPARE, 8'h3C);
        rd_reg(`OFS_STATUS);
        check(rd, 32'h00000000);
        rd_reg(`OFS_COMPARE);
        check(rd, 32'h0000003C);
        rd_reg(8'h20);
        check_err(err, 1'b1);
        check(rd, 32'h00000000);
        wr_reg(8'h24, 8'hA5);
        check_err(err, 1'b1);
        // clock source change: interrupts off, select, rewrite all three
        wr_reg(`OFS_FLAGS, 8'h03);
        wr_reg(`OFS_STATUS, 8'hFF);
        rd_reg(`OFS_STATUS);
        check(rd, 32'h00000008);
        sleep_down <= 1'b1;
        hold[1] = 8'h11;
        for (k = 0; k < 3; k++)
            wr_reg(ofs[k], hold[k]);
        osc_pulse();
        osc_pulse();
        rd_reg(`OFS_STATUS);
        check(rd, 32'h0000000F);
        sleep_down <= 1'b0;
        osc_pulse();
        osc_pulse();
        rd_reg(`OFS_STATUS);
        check(rd, 32'h00000008);
        // random writes and oscillator edges, never writing a busy register
        repeat (40)
        begin
            k = {$random(seed)} % 4;
            if (k < 3 && !busy[k])
            begin
                v = 8'($random(seed));
                // control keeps clock select at stop so the live count stays put
                if (k == 2)
                    v = v & 8'hF8;
                wr_reg(ofs[k], v);
                hold[k] = v;
                busy[k] = 1'b1;
                ticks[k] = 0;
            end
            else
            begin
                osc_pulse();
                for (k = 0; k < 3; k++)
                    if (busy[k] && ++ticks[k] == 2)
                    begin
                        busy[k] = 1'b0;
                        if (k == 0)
                            live = hold[0];
                    end
            end
            rd_reg(`OFS_STATUS);
            check(rd, status_exp());
            rd_reg(`OFS_COUNTER);
            check(rd, {24'h000000, live});
            rd_reg(`OFS_COMPARE);
            check(rd, {24'h000000, hold[1]});
            rd_reg(`OFS_CONTROL);
            check(rd, {24'h000000, hold[2]});
        end
        // drain transfers, then count through overflow and a match while asleep
        repeat (2) osc_pulse();
        if (busy[0])
            live = hold[0];
        wr_reg(`OFS_FLAGS, 8'h33);
        wr_reg(`OFS_COUNTER, 8'hFE);
        wr_reg(`OFS_COMPARE, 8'h00);
        wr_reg(`OFS_CONTROL, 8'h11);
        repeat (2) osc_pulse();
        sleep_save <= 1'b1;
        repeat (3) osc_pulse();
        sleep_save <= 1'b0;
        rd_reg(`OFS_COUNTER);
        check(rd, 32'h00000001);
        rd_reg(`OFS_FLAGS);
        check(rd, 32'h00000033);
        check_bit(compare_pin, 1'b1);
        check_bit(compare_flag, 1'b1);
        check_bit(overflow_flag, 1'b1);
        check(32'(n_wake), 32'h00000001);
        wr_reg(`OFS_FLAGS, 8'h03);
        rd_reg(`OFS_FLAGS);
        check(rd, 32'h00000000);
        print_verdict();
    end
endmodule : async_timer_tb

//--- cpu_core_model.sv
// cpu core model: apb master that reaches the timer registers
`timescale 1ns/1ps
module cpu_core_model
(
    // clock
    input wire logic clk,
    // apb master side
    output async_timer_pkg::apb_req_t apb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    import async_timer_pkg::*;

    initial
    begin
        apb = '0;
    end

    // the request stands unchanged until pready is seen high at a rising edge
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] wd,
        output logic [31:0] rd, output logic err);
        begin
            @(posedge clk);
            apb.psel <= 1'b1;
            apb.penable <= 1'b0;
            apb.pwrite <= wr;
            apb.paddr <= addr;
            apb.pwdata <= {24'h000000, wd};
            @(posedge clk);
            apb.penable <= 1'b1;
            @(posedge clk);
            // no limit here: only the bench watchdog ends a hung wait
            while (pready !== 1'b1)
                @(posedge clk);
            rd = prdata;
            err = pslverr;
            apb.psel <= 1'b0;
            apb.penable <= 1'b0;
        end
    endtask : xfer
endmodule : cpu_core_model

//--- tick_prescaler.sv
// divides timer clock ticks into counting enables
`timescale 1ns/1ps
module tick_prescaler
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // tick in, enable out
    input wire logic tick,
    input wire logic [2:0] clk_sel,
    output logic count_en
);
    import async_timer_pkg::*;

    logic [9:0] div, next_div;

    function automatic logic div_hit(input logic [2:0] sel, input logic [9:0] d);
        case (sel)
            3'h1: div_hit = 1'b1;
            3'h2: div_hit = (d[2:0] == 3'h7);
            3'h3: div_hit = (d[4:0] == 5'h1F);
            3'h4: div_hit = (d[5:0] == 6'h3F);
            3'h5: div_hit = (d[6:0] == 7'h7F);
            3'h6: div_hit = (d[7:0] == 8'hFF);
            3'h7: div_hit = (d == 10'h3FF);
            default: div_hit = 1'b0;
        endcase
    endfunction : div_hit

    always_comb
    begin
        next_div = div;
        if (clk_sel == 3'h0)
            next_div = 10'h000;
        else if (tick)
            next_div = div + 10'h001;
    end

    assign count_en = tick && div_hit(clk_sel, div);

    always_ff @(posedge clk)
    begin
        if (!nrst)
            div <= 10'h000;
        else
            div <= next_div;
    end

endmodule : tick_prescaler

//--- update_slot.sv
// holding register, transfer counter and busy flag for one timer register
`timescale 1ns/1ps
module update_slot
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // cpu side
    input wire logic write,
    input wire logic [7:0] wdata,
    input wire logic async_mode,
    // timer side
    input wire logic osc_tick,
    output logic [7:0] hold,
    output logic load,
    output logic busy
);
    import async_timer_pkg::*;
    `include "async_timer_defs.svh"

    logic pend, next_pend, next_load, next_busy;
    logic [1:0] edges, next_edges;
    logic [7:0] next_hold;
    logic [`DONE_SYNC_STAGES-1:0] done_sync, next_done_sync;

    always_comb
    begin
        next_hold = hold;
        next_pend = pend;
        next_edges = edges;
        next_load = 1'b0;
        next_busy = busy;
        next_done_sync = {done_sync[`DONE_SYNC_STAGES-2:0], 1'b0};
        if (pend && osc_tick)
        begin
            next_edges = edges + 2'h1;
            if (edges + 2'h1 == `TRANSFER_EDGES)
            begin
                next_load = 1'b1;
                next_pend = 1'b0;
                next_done_sync[0] = 1'b1;
            end
        end
        // completion leaves through a short synchroniser before busy drops
        if (done_sync[`DONE_SYNC_STAGES-1])
            next_busy = 1'b0;
        if (write)
        begin
            next_hold = wdata;
            next_edges = 2'h0;
            next_done_sync = '0;
            if (async_mode)
            begin
                next_pend = 1'b1;
                next_busy = 1'b1;
                next_load = 1'b0;
            end
            else
            begin
                next_pend = 1'b0;
                next_load = 1'b1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            hold <= `RESET_BYTE;
            pend <= 1'b0;
            edges <= 2'h0;
            load <= 1'b0;
            busy <= 1'b0;
            done_sync <= '0;
        end
        else
        begin
            hold <= next_hold;
            pend <= next_pend;
            edges <= next_edges;
            load <= next_load;
            busy <= next_busy;
            done_sync <= next_done_sync;
        end
    end

endmodule : update_slot
